// >>> ea_gen_map.svh
// constants for effective-address generation and stack limit checking
// Operation
// RULE_01: stack pointer marks first free word, grows upward
// RULE_02: pop pre-decrements, push post-increments the pointer
// RULE_03: call push zero-extends program counter top part
// RULE_04: exception push joins status low byte to counter
// RULE_05: stack limit bit zero always reads zero
// RULE_06: every stack-pointer address compared against stack limit; code compares only pushes, by pointer value
// RULE_07: push at limit allowed, next push traps
// RULE_08: stack pointer below 0x0800 raises underflow trap
// RULE_09: stack limit register has no reset value
// RULE_10: software avoids stack-pointer read right after limit write
// RULE_11: file register address is 13 bits, near space
// RULE_12: file ops default to working register zero
// RULE_13: three-operand: base direct, operand two register/memory/literal
// RULE_14: indirect address equals pointer register contents
// RULE_15: post-modify uses pointer then steps it
// RULE_16: pre-modify steps pointer then uses it
// RULE_17: indexed address is pointer plus base register
// RULE_18: literal offset address is pointer plus literal
// RULE_19: move and accumulator ops add indexed mode
// RULE_20: move source and destination share offset field
// RULE_21: move reaches whole data space; code still forms move addresses from the 13-bit file field
// RULE_22: one stack error request in offending cycle; code registers it, trap rises one clock later
`ifndef EA_GEN_MAP_SVH
`define EA_GEN_MAP_SVH
`define SP_INDEX 4'hf
`define DEFAULT_WORKING_REGISTER_INDEX 4'h0
`define SFR_TOP 16'h0800
`define NEAR_MASK 16'h1fff
`define WORD_STEP 16'h0002
`define REG_RESET 16'h0000
`endif

// >>> ea_gen_pkg.sv
// types for effective-address generation
package ea_gen_pkg;
  typedef enum logic [7:0] {
    MODE_FILE = 8'h01,
    MODE_DIRECT = 8'h02,
    MODE_IND = 8'h04,
    MODE_POST = 8'h08,
    MODE_PRE = 8'h10,
    MODE_INDEX = 8'h20,
    MODE_LIT = 8'h40,
    MODE_IMM = 8'h80
  } ea_mode_t;
  typedef enum logic [3:0] {
    ST_NONE = 4'h1,
    ST_PUSH = 4'h2,
    ST_POP = 4'h4,
    ST_ACCESS = 4'h8
  } stack_op_t;
  typedef enum logic [2:0] {
    PUSH_DATA = 3'h1,
    PUSH_CALL = 3'h2,
    PUSH_EXC = 3'h4
  } push_src_t;
endpackage

// >>> ea_stack_check.sv
// stack limit and underflow comparison
`timescale 1ns/1ns
`default_nettype none
`include "ea_gen_map.svh"
module ea_stack_check
(
  input wire logic [15:0] addr, // effective address formed from stack pointer
  input wire logic [15:0] sp_value, // stack pointer before the access
  input wire logic [15:0] limit, // stack limit value
  input wire logic is_push, // access is a push
  input wire logic uses_sp, // address came from stack pointer
  output logic overflow, // push past limit
  output logic underflow // address inside sfr area
);
  // push exactly at limit is legal; only addresses past it trap
  assign overflow = uses_sp && is_push && (sp_value > limit); // RULE_06 RULE_07
  assign underflow = uses_sp && (addr < `SFR_TOP); // RULE_08
endmodule
`default_nettype wire

// >>> ea_gen_stack_limit_check.sv
// effective-address generator with stack pointer and limit checks
`timescale 1ns/1ns
`default_nettype none
`include "ea_gen_map.svh"
module ea_gen_stack_limit_check
  import ea_gen_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic op_valid, // decoder presents an operand request
  input wire logic [7:0] op_mode, // one-hot addressing mode
  input wire logic [3:0] op_stack, // one-hot stack operation
  input wire logic [2:0] op_push_src, // one-hot push data source
  input wire logic [3:0] ptr_sel, // pointer register index
  input wire logic [3:0] base_sel, // shared offset register index
  input wire logic ptr_dec, // modify step is a decrement
  input wire logic [15:0] mod_step, // modify constant in bytes
  input wire logic [15:0] lit_offset, // signed literal offset
  input wire logic [12:0] file_addr, // file register address field
  input wire logic is_move, // move instruction, same 13-bit file address as other file ops
  input wire logic [15:0] push_data, // ordinary push operand
  input wire logic [22:0] pc_value, // program counter to push
  input wire logic [7:0] status_low_byte, // status byte for exceptions
  input wire logic wr_en, // working register write from core
  input wire logic [3:0] wr_sel, // working register index
  input wire logic [15:0] wr_data, // working register data
  input wire logic limit_wr, // stack limit register write
  input wire logic [15:0] limit_data, // stack limit write data
  output logic [15:0] effective_address, // address to data memory
  output logic ea_valid, // address valid
  output logic [15:0] push_word_lo, // low word of pushed value
  output logic [15:0] push_word_hi, // high word of pushed value
  output logic [15:0] base_value, // base register operand
  output logic [15:0] default_working_register_value, // default working register
  output logic [15:0] stack_pointer_register, // current stack pointer
  output logic stack_error_trap // one-cycle trap request
);
  logic [15:0] default_working_register_file [0:15];
  logic [15:0] stack_limit_register;
  logic [15:0] ptr_val;
  logic [15:0] base_val;
  logic [15:0] step;
  logic [15:0] moved;
  logic [15:0] ea_next;
  logic [15:0] ptr_next;
  logic ptr_update;
  logic [15:0] lo_next;
  logic [15:0] hi_next;
  logic uses_sp;
  logic ovf;
  logic unf;
  ea_mode_t mode;
  stack_op_t sop;
  push_src_t psrc;

  assign mode = ea_mode_t'(op_mode);
  assign sop = stack_op_t'(op_stack);
  assign psrc = push_src_t'(op_push_src);
  assign ptr_val = (sop == ST_PUSH || sop == ST_POP) ?
    default_working_register_file[`SP_INDEX] : default_working_register_file[ptr_sel];
  assign base_val = default_working_register_file[base_sel]; // RULE_20
  assign step = ptr_dec ? (16'h0000 - mod_step) : mod_step;
  assign moved = ptr_val + step;

  always_comb
  begin
    ea_next = ptr_val;
    ptr_next = ptr_val;
    ptr_update = 1'b0;
    uses_sp = 1'b0;
    case (sop)
      ST_PUSH:
      begin
        ea_next = ptr_val; // RULE_01
        ptr_next = ptr_val + `WORD_STEP; // RULE_02
        ptr_update = 1'b1;
        uses_sp = 1'b1;
      end
      ST_POP:
      begin
        ea_next = ptr_val - `WORD_STEP; // RULE_02
        ptr_next = ea_next;
        ptr_update = 1'b1;
        uses_sp = 1'b1;
      end
      default:
      begin
        case (mode)
          MODE_FILE:
          begin
            if (is_move)
              ea_next = {3'h0, file_addr}; // RULE_21
            else
              ea_next = {3'h0, file_addr} & `NEAR_MASK; // RULE_11
          end
          MODE_DIRECT: ea_next = ptr_val;
          MODE_IND: ea_next = ptr_val; // RULE_14
          MODE_POST:
          begin
            ea_next = ptr_val; // RULE_15
            ptr_next = moved;
            ptr_update = 1'b1;
          end
          MODE_PRE:
          begin
            ea_next = moved; // RULE_16
            ptr_next = moved;
            ptr_update = 1'b1;
          end
          MODE_INDEX: ea_next = ptr_val + base_val; // RULE_17 RULE_19
          MODE_LIT: ea_next = ptr_val + lit_offset; // RULE_18
          MODE_IMM: ea_next = lit_offset; // RULE_13
          default: ea_next = ptr_val;
        endcase
        uses_sp = (ptr_sel == `SP_INDEX) && (mode != MODE_FILE) &&
          (mode != MODE_DIRECT) && (mode != MODE_IMM); // RULE_06
      end
    endcase
  end

  always_comb
  begin
    lo_next = push_data;
    hi_next = 16'h0000;
    case (psrc)
      PUSH_CALL:
      begin
        lo_next = pc_value[15:0];
        hi_next = {9'h000, pc_value[22:16]}; // RULE_03
      end
      PUSH_EXC:
      begin
        lo_next = pc_value[15:0];
        hi_next = {status_low_byte, 1'b0, pc_value[22:16]}; // RULE_04
      end
      default:
      begin
        lo_next = push_data;
        hi_next = 16'h0000;
      end
    endcase
  end

  ea_stack_check u_check
  (
    .addr(ea_next),
    .sp_value(default_working_register_file[`SP_INDEX]),
    .limit(stack_limit_register),
    .is_push(sop == ST_PUSH),
    .uses_sp(uses_sp && op_valid),
    .overflow(ovf),
    .underflow(unf)
  );

  // no reset: limit is undefined until software writes it
  always_ff @(posedge ref_clk) // RULE_09
  begin
    if (limit_wr)
      stack_limit_register <= {limit_data[15:1], 1'b0}; // RULE_05
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_default_working_register
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          default_working_register_file[gi] <= `REG_RESET;
        else if (op_valid && ptr_update &&
                 ((sop == ST_PUSH || sop == ST_POP) ? (gi == 15) :
                  (ptr_sel == 4'(gi))))
          default_working_register_file[gi] <= ptr_next;
        else if (wr_en && wr_sel == 4'(gi))
          default_working_register_file[gi] <= (gi == 15) ? {wr_data[15:1], 1'b0} : wr_data;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      effective_address <= `REG_RESET;
      ea_valid <= 1'b0;
    end
    else
    begin
      effective_address <= ea_next;
      ea_valid <= op_valid;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      push_word_lo <= `REG_RESET;
      push_word_hi <= `REG_RESET;
    end
    else
    begin
      push_word_lo <= lo_next;
      push_word_hi <= hi_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      base_value <= `REG_RESET;
      default_working_register_value <= `REG_RESET;
      stack_pointer_register <= `REG_RESET;
    end
    else
    begin
      base_value <= base_val; // RULE_13
      default_working_register_value <= default_working_register_file[`DEFAULT_WORKING_REGISTER_INDEX]; // RULE_12
      stack_pointer_register <= default_working_register_file[`SP_INDEX];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stack_error_trap <= 1'b0;
    else
      stack_error_trap <= ovf || unf; // RULE_22
  end

  a_push_post_inc: assert property ( // RULE_02
    @(posedge ref_clk) disable iff (rst)
    op_valid && sop == ST_PUSH && !wr_en |=>
    default_working_register_file[15] == $past(default_working_register_file[15]) + 16'h0002)
    else $error("push did not advance stack pointer");
  a_pop_pre_dec: assert property ( // RULE_02
    @(posedge ref_clk) disable iff (rst)
    op_valid && sop == ST_POP |=>
    effective_address == $past(default_working_register_file[15]) - 16'h0002)
    else $error("pop address not pre-decremented");
  a_push_addr_sp: assert property ( // RULE_01
    @(posedge ref_clk) disable iff (rst)
    op_valid && sop == ST_PUSH |=>
    effective_address == $past(default_working_register_file[15]))
    else $error("push address is not free word");
  a_limit_bit0: assert property ( // RULE_05
    @(posedge ref_clk) disable iff (rst)
    $past(limit_wr) |->
    stack_limit_register == {$past(limit_data[15:1]), 1'b0})
    else $error("limit write not word aligned");
  a_call_msb: assert property ( // RULE_03
    @(posedge ref_clk) disable iff (rst)
    psrc == PUSH_CALL |=> push_word_hi[15:7] == 9'h000)
    else $error("call push top bits not clear");
  a_exc_srl: assert property ( // RULE_04
    @(posedge ref_clk) disable iff (rst)
    psrc == PUSH_EXC |=> push_word_hi[15:8] == $past(status_low_byte))
    else $error("exception push lost status byte");
  a_at_limit_ok: assert property ( // RULE_07
    @(posedge ref_clk) disable iff (rst)
    op_valid && sop == ST_PUSH && default_working_register_file[15] == stack_limit_register &&
    default_working_register_file[15] >= 16'h0800 |=> !stack_error_trap)
    else $error("push at limit trapped");
  a_over_trap: assert property ( // RULE_07
    @(posedge ref_clk) disable iff (rst)
    op_valid && sop == ST_PUSH && default_working_register_file[15] > stack_limit_register
    |=> stack_error_trap)
    else $error("push past limit did not trap");
  // pointer values below two wrap on pop and leave the sfr area
  a_under_trap: assert property ( // RULE_08
    @(posedge ref_clk) disable iff (rst)
    op_valid && sop == ST_POP &&
    default_working_register_file[15] inside {[16'h0002:16'h0801]}
    |=> stack_error_trap)
    else $error("underflow did not trap");
  a_index_sum: assert property ( // RULE_17
    @(posedge ref_clk) disable iff (rst)
    op_valid && !(sop inside {ST_PUSH, ST_POP}) &&
    mode == MODE_INDEX |=>
    effective_address == $past(default_working_register_file[ptr_sel] + default_working_register_file[base_sel]))
    else $error("indexed address wrong");
  a_pre_mod: assert property ( // RULE_16
    @(posedge ref_clk) disable iff (rst)
    op_valid && !(sop inside {ST_PUSH, ST_POP}) &&
    mode == MODE_PRE |=>
    effective_address == $past(ptr_dec ? default_working_register_file[ptr_sel] - mod_step :
    default_working_register_file[ptr_sel] + mod_step))
    else $error("pre-modified address wrong");
  a_post_mod: assert property ( // RULE_15
    @(posedge ref_clk) disable iff (rst)
    op_valid && !(sop inside {ST_PUSH, ST_POP}) &&
    mode == MODE_POST |=>
    effective_address == $past(default_working_register_file[ptr_sel]))
    else $error("post-modified address wrong");
  a_ind_addr: assert property ( // RULE_14
    @(posedge ref_clk) disable iff (rst)
    op_valid && !(sop inside {ST_PUSH, ST_POP}) &&
    mode == MODE_IND |=>
    effective_address == $past(default_working_register_file[ptr_sel]))
    else $error("indirect address wrong");
  a_lit_offset: assert property ( // RULE_18
    @(posedge ref_clk) disable iff (rst)
    op_valid && !(sop inside {ST_PUSH, ST_POP}) &&
    mode == MODE_LIT |=>
    effective_address == $past(default_working_register_file[ptr_sel] + lit_offset))
    else $error("literal offset address wrong");
  a_near_space: assert property ( // RULE_11
    @(posedge ref_clk) disable iff (rst)
    op_valid && !(sop inside {ST_PUSH, ST_POP}) &&
    mode == MODE_FILE |=>
    effective_address[15:13] == 3'h0)
    else $error("file address beyond near space");
  // a trap without a request would point the core at the wrong access
  a_trap_cause: assert property ( // RULE_22
    @(posedge ref_clk) disable iff (rst)
    stack_error_trap |-> $past(op_valid))
    else $error("stack trap without a request");
endmodule
`default_nettype wire

// >>> ea_decoder_model.sv
// decoder stand-in that drives operand requests into the generator
`timescale 1ns/1ns
`default_nettype none
module ea_decoder_model
(
  input wire logic ref_clk, // core clock
  output logic op_valid, // request
  output logic [7:0] op_mode, // mode
  output logic [3:0] op_stack, // stack op
  output logic [2:0] op_push_src, // push source
  output logic [3:0] ptr_sel, // pointer
  output logic [3:0] base_sel, // offset reg
  output logic ptr_dec, // step down
  output logic [15:0] mod_step, // step
  output logic [15:0] lit_offset, // literal
  output logic [12:0] file_addr, // file field
  output logic is_move, // move op
  output logic [15:0] push_data, // push word
  output logic [22:0] pc_value, // counter
  output logic [7:0] status_low_byte, // status
  output logic wr_en, // reg write
  output logic [3:0] wr_sel, // reg index
  output logic [15:0] wr_data, // reg data
  output logic limit_wr, // limit write
  output logic [15:0] limit_data // limit data
);
  initial
  begin
    {op_valid, op_mode, op_stack, op_push_src, ptr_sel, base_sel} = '0;
    {ptr_dec, mod_step, lit_offset, file_addr, is_move, push_data} = '0;
    {pc_value, status_low_byte, wr_en, wr_sel, wr_data} = '0;
    {limit_wr, limit_data} = '0;
  end
  // each task owns one cycle and clears the other strobes
  task automatic issue(input logic [7:0] m, input logic [3:0] s,
    input logic [3:0] p, input logic [3:0] b, input logic [63:0] r);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_mode <= m;
    op_stack <= s;
    ptr_sel <= p;
    base_sel <= b;
    op_push_src <= 3'h1 << (r[1:0] % 2'd3);
    ptr_dec <= r[2];
    // even steps only: stack pointer bit zero is forced low
    mod_step <= {10'h0, r[7:3], 1'b0};
    lit_offset <= r[23:8];
    file_addr <= r[36:24];
    is_move <= r[37];
    push_data <= r[53:38];
    pc_value <= r[63:41];
    status_low_byte <= r[47:40];
    wr_en <= 1'b0;
    limit_wr <= 1'b0;
  endtask
  task automatic put(input logic l, input logic [3:0] i,
    input logic [15:0] d);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    wr_en <= !l;
    limit_wr <= l;
    wr_sel <= i;
    wr_data <= d;
    limit_data <= d;
  endtask
  task automatic idle();
    @(posedge ref_clk);
    op_valid <= 1'b0;
    wr_en <= 1'b0;
    limit_wr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for address generation and stack checks
`timescale 1ns/1ns
`default_nettype none
module tb
  import ea_gen_pkg::*;
;
  logic ref_clk, rst, op_valid, ptr_dec, is_move, wr_en, limit_wr;
  logic [7:0] op_mode, status_low_byte;
  logic [3:0] op_stack, ptr_sel, base_sel, wr_sel;
  logic [2:0] op_push_src;
  logic [15:0] mod_step, lit_offset, push_data, wr_data, limit_data;
  logic [12:0] file_addr;
  logic [22:0] pc_value;
  logic [15:0] effective_address, push_word_lo, push_word_hi;
  logic [15:0] base_value, default_working_register_value, stack_pointer_register;
  logic ea_valid, stack_error_trap, ev, et, ep, sk;
  logic [15:0] w [16];
  logic [15:0] lim, ea_x, lo_x, hi_x, t;
  int errors = 0, n_compared = 0, seed = 32'h3de0, k;
  ea_mode_t modes [8] = '{MODE_FILE, MODE_DIRECT, MODE_IND, MODE_POST,
    MODE_PRE, MODE_INDEX, MODE_LIT, MODE_IMM};
  ea_decoder_model dec (.ref_clk, .op_valid, .op_mode, .op_stack,
    .op_push_src, .ptr_sel, .base_sel, .ptr_dec, .mod_step, .lit_offset,
    .file_addr, .is_move, .push_data, .pc_value, .status_low_byte, .wr_en,
    .wr_sel, .wr_data, .limit_wr, .limit_data);
  ea_gen_stack_limit_check uut (.ref_clk, .rst, .op_valid, .op_mode,
    .op_stack, .op_push_src, .ptr_sel, .base_sel, .ptr_dec, .mod_step,
    .lit_offset, .file_addr, .is_move, .push_data, .pc_value,
    .status_low_byte, .wr_en, .wr_sel, .wr_data, .limit_wr, .limit_data,
    .effective_address, .ea_valid, .push_word_lo, .push_word_hi,
    .base_value, .default_working_register_value, .stack_pointer_register, .stack_error_trap);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // model reads the registers as they stood before the taking edge
  task automatic step_model();
    logic [15:0] p;
    p = w[ptr_sel];
    t = ptr_dec ? -mod_step : mod_step;
    if (op_stack == ST_PUSH)
    begin
      ea_x = w[15];
      et = w[15] > lim || w[15] < 16'h0800;
      w[15] = w[15] + 16'h2;
      ep = 1'b1;
      lo_x = op_push_src == PUSH_DATA ? push_data : pc_value[15:0];
      hi_x = op_push_src == PUSH_CALL ? {9'h0, pc_value[22:16]} :
        op_push_src == PUSH_EXC ? {status_low_byte, 1'b0, pc_value[22:16]}
        : 16'h0;
    end
    else if (op_stack == ST_POP)
    begin
      w[15] = w[15] - 16'h2;
      ea_x = w[15];
      et = ea_x < 16'h0800;
    end
    else
    begin
      case (op_mode)
        MODE_FILE: ea_x = {3'h0, file_addr};
        MODE_DIRECT: sk = 1'b1;
        MODE_IND: ea_x = p;
        MODE_POST: {ea_x, w[ptr_sel]} = {p, p + t};
        MODE_PRE: {ea_x, w[ptr_sel]} = {p + t, p + t};
        MODE_INDEX: ea_x = p + w[base_sel];
        MODE_LIT: ea_x = p + lit_offset;
        default: ea_x = lit_offset;
      endcase
      et = ptr_sel == 4'hf && ea_x < 16'h0800 && !sk &&
        op_mode inside {MODE_IND, MODE_POST, MODE_PRE, MODE_INDEX, MODE_LIT};
    end
  endtask
  always @(posedge ref_clk)
    if (rst)
    begin
      {ev, et, ep, sk} = '0;
      foreach (w[i]) w[i] = '0;
    end
    else
    begin
      chk(ea_valid, ev);
      if (ev && !sk) chk(effective_address, ea_x);
      if (ev) chk(stack_error_trap, et);
      if (ep) chk(push_word_lo, lo_x);
      if (ep) chk(push_word_hi, hi_x);
      {ev, et, ep, sk} = {op_valid, 3'b0};
      if (op_valid) step_model();
      if (wr_en) w[wr_sel] = wr_data & {15'h7fff, wr_sel != 4'hf};
      if (limit_wr) lim = limit_data & 16'hfffe;
    end
  task automatic go(input logic [7:0] m, input logic [3:0] s, p, b);
    dec.issue(m, s, p, b, {$random(seed), $random(seed)});
  endtask
  task automatic settle();
    repeat (3) dec.idle();
    #1;
    chk(stack_pointer_register, w[15]);
    chk(default_working_register_value, w[0]);
    chk(base_value, w[base_sel]);
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    dec.put(0, 15, 16'h1000);
    dec.put(0, 1, 16'h2000);
    dec.put(0, 2, 16'h0010);
    dec.put(0, 0, 16'h1234);
    dec.put(1, 0, 16'h1001);
    dec.idle();
    repeat (3) go(MODE_IND, ST_PUSH, 1, 2);
    repeat (3) go(MODE_IND, ST_POP, 1, 2);
    settle();
    foreach (modes[i]) go(modes[i], ST_ACCESS, 1, 2);
    settle();
    dec.put(0, 15, 16'h0802);
    repeat (2) go(MODE_IND, ST_POP, 1, 2);
    go(MODE_PRE, ST_ACCESS, 15, 2);
    settle();
    repeat (300)
    begin
      k = $random(seed);
      if (k[3])
        dec.put(0, k[7:4], k[31:16]);
      else
        go(modes[k[2:0]], 4'h2 << ($unsigned(k) % 3), k[7:4], k[11:8]);
      if (k[15:12] == 4'h0) settle();
    end
    settle();
    give_verdict();
  end
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
